// ---- src/uab_dev.sv ----
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "uab_map.svh"
module uab_dev
   import uab_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   output logic txe_req, // Buffer empty request
   output logic rx_hold, // Receiver held idle
   uab_link_if.dev lnk // Serial line
);
   uab_dev_st_t q, d;
   logic acc, wr, rd, rise, fall, tick, bit_end, tx_on, set_txbe;
   logic [6:0] ov;
   logic [31:0] rdv;

   always_comb begin
      d = q;
      set_txbe = 1'b0;
      tick = 1'b0;
      acc = psel & penable;
      wr = acc & pwrite & q.pready;
      rd = acc & ~pwrite & q.pready;
      rise = lnk.rem_txd & ~q.rx_q;
      fall = ~lnk.rem_txd & q.rx_q;
      d.rx_q = lnk.rem_txd;
      ov = uab_ov(q.high_speed_baud_select, q.wide_generator_select);
      tx_on = q.serial_port_enable & ~q.sync & q.transmit_enable & ~q.autobaud_enable;

      // Register read mux, answered one cycle after the access phase starts
      rdv = `UAB_WORD_RST;
      d.pslverr = 1'b0;
      unique case (paddr)
         `UAB_CTRL_OFF: begin
            rdv[`UAB_C_SERIAL_PORT_ENABLE] = q.serial_port_enable;
            rdv[`UAB_C_SYNC] = q.sync;
            rdv[`UAB_C_TRANSMIT_ENABLE] = q.transmit_enable;
            rdv[`UAB_C_TX9] = q.tx9;
            rdv[`UAB_C_NINTH_TRANSMIT_BIT] = q.ninth_transmit_bit;
            rdv[`UAB_C_HIGH_SPEED_BAUD_SELECT] = q.high_speed_baud_select;
            rdv[`UAB_C_WIDE_GENERATOR_SELECT] = q.wide_generator_select;
            rdv[`UAB_C_WUE] = q.wake_on_activity_enable;
            rdv[`UAB_C_AUTOBAUD_ENABLE] = q.autobaud_enable;
            rdv[`UAB_C_ABOVF] = q.abovf;
            rdv[`UAB_C_TRANSMIT_EMPTY_IRQ_ENABLE] = q.transmit_empty_irq_enable;
         end
         `UAB_STAT_OFF: begin
            rdv[`UAB_S_TXBE] = q.txbe;
            rdv[`UAB_S_SHIFTER_EMPTY_BIT] = (q.tx_st == TX_IDLE) | (q.tx_st == TX_LOAD);
            rdv[`UAB_S_RCF] = q.rcf;
         end
         `UAB_DIV_OFF: rdv[15:0] = q.div;
         `UAB_TXD_OFF: rdv[7:0] = q.txbuf;
         `UAB_RXD_OFF: rdv = `UAB_WORD_RST;
         default: d.pslverr = acc & ~q.pready;
      endcase
      d.pready = acc & ~q.pready;
      d.prdata = (acc & ~q.pready) ? rdv : `UAB_WORD_RST;

      // Software writes
      if (wr && paddr == `UAB_CTRL_OFF) begin
         d.serial_port_enable = pwdata[`UAB_C_SERIAL_PORT_ENABLE];
         d.sync = pwdata[`UAB_C_SYNC];
         d.transmit_enable = pwdata[`UAB_C_TRANSMIT_ENABLE];
         d.tx9 = pwdata[`UAB_C_TX9];
         d.ninth_transmit_bit = pwdata[`UAB_C_NINTH_TRANSMIT_BIT];
         d.high_speed_baud_select = pwdata[`UAB_C_HIGH_SPEED_BAUD_SELECT];
         d.wide_generator_select = pwdata[`UAB_C_WIDE_GENERATOR_SELECT];
         d.wake_on_activity_enable = pwdata[`UAB_C_WUE];
         d.autobaud_enable = pwdata[`UAB_C_AUTOBAUD_ENABLE] & ~pwdata[`UAB_C_SYNC];
         d.abovf = pwdata[`UAB_C_ABOVF];
         d.transmit_empty_irq_enable = pwdata[`UAB_C_TRANSMIT_EMPTY_IRQ_ENABLE];
         if (pwdata[`UAB_C_TRANSMIT_ENABLE] & ~q.transmit_enable) set_txbe = 1'b1;
         if (d.autobaud_enable & ~q.autobaud_enable) begin
            d.div = `UAB_DIV_RST;
            d.pre = '0;
            d.ab_st = pwdata[`UAB_C_WUE] ? AB_BRK : AB_START;
         end
         if (!d.autobaud_enable) d.ab_st = AB_OFF;
      end
      if (wr && paddr == `UAB_DIV_OFF && !q.autobaud_enable) d.div = pwdata[15:0];
      // Buffer writes during measurement are dropped: the generator is busy
      if (wr && paddr == `UAB_TXD_OFF && !q.autobaud_enable) begin
         d.txbuf = pwdata[7:0];
         d.buf_full = 1'b1;
         d.wr_dly = `UAB_TCY_CLKS;
      end
      if (rd && paddr == `UAB_RXD_OFF) d.rcf = 1'b0;

      // Flag drops only once the first instruction cycle after the write ends
      if (q.wr_dly != 3'd0) begin
         d.wr_dly = q.wr_dly - 3'd1;
         if (q.wr_dly == 3'd1) d.txbe = 1'b0;
      end

      // Bit clock: down-counter reloaded from the divisor
      if (tx_on) begin
         if (q.baud_generator == 16'h0000) begin
            d.baud_generator = q.wide_generator_select ? q.div : {8'h00, q.div[7:0]};
            tick = 1'b1;
         end else begin
            d.baud_generator = q.baud_generator - 16'd1;
         end
      end
      bit_end = tick & (q.ovc == ov - 7'd1);
      if (tick) d.ovc = bit_end ? 7'd0 : q.ovc + 7'd1;

      unique case (q.tx_st)
         TX_IDLE: if (tx_on & q.buf_full) begin
            d.tx_st = TX_LOAD;
            d.ld_cnt = `UAB_TCY_CLKS - 3'd1;
         end
         TX_LOAD: if (q.ld_cnt == 3'd0) begin
            d.transmit_shifter = {q.tx9 & q.ninth_transmit_bit, q.txbuf};
            d.buf_full = 1'b0;
            set_txbe = 1'b1;
            d.tx_st = TX_START;
            d.bcnt = 4'd0;
            d.ovc = 7'd0;
         end else begin
            d.ld_cnt = q.ld_cnt - 3'd1;
         end
         TX_START: if (bit_end) d.tx_st = TX_DATA;
         TX_DATA: if (bit_end) begin
            d.transmit_shifter = {1'b0, q.transmit_shifter[8:1]};
            d.bcnt = q.bcnt + 4'd1;
            if (q.bcnt == (q.tx9 ? 4'd8 : 4'd7)) d.tx_st = TX_STOP;
         end
         TX_STOP: if (bit_end) d.tx_st = TX_IDLE;
      endcase
      if (!tx_on) d.tx_st = TX_IDLE;
      if (set_txbe) d.txbe = 1'b1;
      d.txd = (d.tx_st == TX_START) ? 1'b0 :
              (d.tx_st == TX_DATA) ? d.transmit_shifter[0] : 1'b1;

      // Baud measurement
      unique case (q.ab_st)
         AB_OFF: ;
         AB_BRK: if (rise) d.ab_st = AB_START;
         AB_START: if (fall) d.ab_st = AB_EDGE1;
         AB_EDGE1: if (rise) begin
            d.ab_st = AB_MEAS;
            d.edges = 3'd1;
            d.pre = '0;
         end
         AB_MEAS: begin
            if (q.pre == {ov, `UAB_AB_PRE'd0} - 10'd1) begin
               d.pre = '0;
               d.div = q.div + 16'd1;
               if (q.div == 16'hffff) d.abovf = 1'b1;
            end else begin
               d.pre = q.pre + 10'd1;
            end
            if (rise) begin
               d.edges = q.edges + 3'd1;
               if (q.edges == `UAB_AB_EDGES - 3'd1) begin
                  d.autobaud_enable = 1'b0;
                  d.rcf = 1'b1;
                  d.ab_st = AB_OFF;
               end
            end
         end
         default: d.ab_st = AB_OFF;
      endcase
      if (!q.serial_port_enable) d.ab_st = AB_OFF;
      d.rx_hold = d.ab_st != AB_OFF;
      d.txe_req = d.txbe & d.transmit_empty_irq_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.txd <= 1'b1;
         q.rx_q <= 1'b1;
         q.div <= `UAB_DIV_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign txe_req = q.txe_req;
   assign rx_hold = q.rx_hold;
   assign lnk.dev_txd = q.txd;
endmodule

// ---- src/uab_map.svh ----
`ifndef UAB_MAP_SVH
`define UAB_MAP_SVH
// Register offsets (byte addresses, one word each)
`define UAB_CTRL_OFF 12'h000
`define UAB_STAT_OFF 12'h004
`define UAB_DIV_OFF 12'h008
`define UAB_TXD_OFF 12'h00c
`define UAB_RXD_OFF 12'h010
// Control register fields
`define UAB_C_SERIAL_PORT_ENABLE 0
`define UAB_C_SYNC 1
`define UAB_C_TRANSMIT_ENABLE 2
`define UAB_C_TX9 3
`define UAB_C_NINTH_TRANSMIT_BIT 4
`define UAB_C_HIGH_SPEED_BAUD_SELECT 5
`define UAB_C_WIDE_GENERATOR_SELECT 6
`define UAB_C_WUE 7
`define UAB_C_AUTOBAUD_ENABLE 8
`define UAB_C_ABOVF 9
`define UAB_C_TRANSMIT_EMPTY_IRQ_ENABLE 10
// Status register fields
`define UAB_S_TXBE 0
`define UAB_S_SHIFTER_EMPTY_BIT 1
`define UAB_S_RCF 2
// Reset values
`define UAB_DIV_RST 16'h0000
`define UAB_WORD_RST 32'h0000_0000
// Timing: oscillator periods per instruction cycle, oversampling ratios
`define UAB_TCY_CLKS 3'd4
`define UAB_OV_SLOW 7'd64
`define UAB_OV_MID 7'd16
`define UAB_OV_FAST 7'd4
`define UAB_AB_PRE 3
`define UAB_AB_EDGES 3'd5
`define UAB_SYNC_CHAR 8'h55
`endif

// ---- src/uab_pkg.sv ----
`include "uab_map.svh"
package uab_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_STOP} uab_tx_t;
   typedef enum logic [2:0] {AB_OFF, AB_BRK, AB_START, AB_EDGE1, AB_MEAS} uab_ab_t;

   typedef struct packed {
      logic serial_port_enable, sync, transmit_enable, tx9, ninth_transmit_bit, high_speed_baud_select, wide_generator_select, wake_on_activity_enable, autobaud_enable, abovf, transmit_empty_irq_enable;
      logic [15:0] div;
      logic [15:0] baud_generator;
      logic [7:0] txbuf;
      logic buf_full;
      logic [2:0] wr_dly;
      logic [2:0] ld_cnt;
      logic txbe;
      uab_tx_t tx_st;
      logic [8:0] transmit_shifter;
      logic [3:0] bcnt;
      logic [6:0] ovc;
      logic txd;
      uab_ab_t ab_st;
      logic [9:0] pre;
      logic [2:0] edges;
      logic rx_q;
      logic rcf;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic txe_req;
      logic rx_hold;
   } uab_dev_st_t;

   typedef struct packed {
      uab_tx_t tst;
      logic [15:0] tcnt;
      logic [3:0] tbits;
      logic [8:0] tsh;
      logic txd;
      logic sready;
      uab_tx_t rst;
      logic [15:0] rcnt;
      logic [3:0] rbits;
      logic [8:0] rsh;
      logic rx_q;
      logic [8:0] rdata;
      logic rvalid;
   } uab_rem_st_t;

   // Generator ticks per bit for the two select bits
   function automatic logic [6:0] uab_ov(input logic high_speed_baud_select, input logic wide_generator_select);
      unique case ({wide_generator_select, high_speed_baud_select})
         2'b00: uab_ov = `UAB_OV_SLOW;
         2'b11: uab_ov = `UAB_OV_FAST;
         default: uab_ov = `UAB_OV_MID;
      endcase
   endfunction
endpackage

// ---- src/uab_link_if.sv ----
`timescale 1ns/10ps
interface uab_link_if;
   logic dev_txd;
   logic rem_txd;
   modport dev(output dev_txd, input rem_txd);
   modport rem(input dev_txd, output rem_txd);
endinterface

// ---- src/uab_remote.sv ----
`timescale 1ns/10ps
`include "uab_map.svh"
// Remote station: plain NRZ sender and receiver at a fixed bit period
module uab_remote
   import uab_pkg::*;
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic [15:0] bit_clks, // Bit period in clocks, at least 2
   input wire logic nine_bit, // Nine data bits per frame
   input wire logic send_req, // Send request, one-cycle pulse
   input wire logic send_sync, // Send calibration character, pulse
   input wire logic [8:0] send_data, // Byte to send, bit 8 in 9-bit frames
   output logic send_ready, // Sender idle
   output logic [8:0] rcv_data, // Last received frame
   output logic rcv_valid, // Frame received, one-cycle pulse
   uab_link_if.rem lnk // Serial line
);
   uab_rem_st_t q, d;
   logic t_end, r_end;

   always_comb begin
      d = q;
      d.rvalid = 1'b0;
      d.rx_q = lnk.dev_txd;
      t_end = q.tcnt == bit_clks - 16'd1;
      r_end = q.rcnt == bit_clks - 16'd1;
      d.tcnt = t_end ? 16'd0 : q.tcnt + 16'd1;
      d.rcnt = r_end ? 16'd0 : q.rcnt + 16'd1;

      unique case (q.tst)
         TX_IDLE: begin
            d.tcnt = 16'd0;
            if (send_sync) begin
               d.tsh = {1'b1, `UAB_SYNC_CHAR};
               d.tst = TX_START;
            end else if (send_req) begin
               d.tsh = send_data;
               d.tst = TX_START;
            end
         end
         TX_START: if (t_end) begin
            d.tst = TX_DATA;
            d.tbits = 4'd0;
         end
         TX_DATA: if (t_end) begin
            d.tsh = {1'b1, q.tsh[8:1]};
            d.tbits = q.tbits + 4'd1;
            if (q.tbits == (nine_bit ? 4'd8 : 4'd7)) d.tst = TX_STOP;
         end
         TX_STOP: if (t_end) d.tst = TX_IDLE;
         default: d.tst = TX_IDLE;
      endcase
      d.sready = d.tst == TX_IDLE;
      d.txd = (d.tst == TX_START) ? 1'b0 : (d.tst == TX_DATA) ? d.tsh[0] : 1'b1;

      // Receiver samples each bit at its middle
      unique case (q.rst)
         TX_IDLE: begin
            d.rcnt = 16'd0;
            if (!lnk.dev_txd & q.rx_q) begin
               d.rst = TX_START;
               d.rcnt = {1'b0, bit_clks[15:1]};
            end
         end
         TX_START: if (r_end) begin
            d.rst = q.rx_q ? TX_IDLE : TX_DATA;
            d.rbits = 4'd0;
         end
         TX_DATA: if (r_end) begin
            d.rsh = nine_bit ? {q.rx_q, q.rsh[8:1]} : {1'b0, q.rx_q, q.rsh[7:1]};
            d.rbits = q.rbits + 4'd1;
            if (q.rbits == (nine_bit ? 4'd8 : 4'd7)) d.rst = TX_STOP;
         end
         TX_STOP: if (r_end) begin
            d.rst = TX_IDLE;
            d.rdata = q.rsh;
            d.rvalid = q.rx_q;
         end
         default: d.rst = TX_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.txd <= 1'b1;
         q.rx_q <= 1'b1;
         q.sready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign send_ready = q.sready;
   assign rcv_data = q.rdata;
   assign rcv_valid = q.rvalid;
   assign lnk.rem_txd = q.txd;
endmodule

// ---- dv/uab_monitor.sv ----
`timescale 1ns/10ps
module uab_monitor #(
   parameter int BITC = 64
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Reset, active low
   input wire logic dev_txd, // Device to remote line
   input wire logic rem_txd // Remote to device line
);
   // Low-run lengths; an all-zero nine-bit frame stays at ten bits
   logic [10:0] dl_q;
   logic [10:0] rl_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dl_q <= '0;
         rl_q <= '0;
      end else begin
         dl_q <= dev_txd ? 11'h0 : dl_q + 11'h1;
         rl_q <= rem_txd ? 11'h0 : rl_q + 11'h1;
      end
   end
   // Start bit may lose up to one generator tick to phase
   property p_dlow_min; $rose(dev_txd) |-> dl_q >= 11'd48; endproperty
   a_dlow_min: assert property (p_dlow_min) else $error("device low too short");
   property p_dlow_max; dl_q <= 11'd640; endproperty
   a_dlow_max: assert property (p_dlow_max) else $error("device low too long");
   property p_dhigh; $rose(dev_txd) |-> dev_txd [*8]; endproperty
   a_dhigh: assert property (p_dhigh) else $error("device high too short");
   property p_dfall; $fell(dev_txd) |-> (!dev_txd) [*8]; endproperty
   a_dfall: assert property (p_dfall) else $error("device start cut");
   property p_rlow_mult; $rose(rem_txd) |-> (rl_q % BITC) == 0; endproperty
   a_rlow_mult: assert property (p_rlow_mult) else $error("remote low run");
   property p_rlow_max; rl_q <= 11'd640; endproperty
   a_rlow_max: assert property (p_rlow_max) else $error("remote low too long");
   property p_rhigh; $rose(rem_txd) |-> rem_txd [*2]; endproperty
   a_rhigh: assert property (p_rhigh) else $error("remote high too short");
   property p_rfall; $fell(rem_txd) |=> !rem_txd; endproperty
   a_rfall: assert property (p_rfall) else $error("remote start cut");
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`include "uab_map.svh"
module tb;
   localparam logic [31:0] c_sp = 32'h1 << `UAB_C_SERIAL_PORT_ENABLE, c_sy = 32'h1 << `UAB_C_SYNC;
   localparam logic [31:0] c_tx = 32'h1 << `UAB_C_TRANSMIT_ENABLE, c_t9 = 32'h1 << `UAB_C_TX9;
   localparam logic [31:0] c_td = 32'h1 << `UAB_C_NINTH_TRANSMIT_BIT, c_hi = 32'h1 << `UAB_C_HIGH_SPEED_BAUD_SELECT;
   localparam logic [31:0] c_wi = 32'h1 << `UAB_C_WIDE_GENERATOR_SELECT, c_wu = 32'h1 << `UAB_C_WUE;
   localparam logic [31:0] c_ab = 32'h1 << `UAB_C_AUTOBAUD_ENABLE, c_ov = 32'h1 << `UAB_C_ABOVF;
   localparam logic [31:0] c_ie = 32'h1 << `UAB_C_TRANSMIT_EMPTY_IRQ_ENABLE;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txe_req, rx_hold;
   logic nine_bit, send_req, send_sync, send_ready, rcv_valid, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [8:0] send_data, rcv_data;
   int fails = 0;
   int tests_run = 0;
   uab_link_if lnk();
   uab_dev i_uab_dev(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .txe_req(txe_req), .rx_hold(rx_hold), .lnk(lnk));
   // Remote bit fixed at 64 clocks: every device setting below is tuned to match
   uab_remote i_uab_remote(.pclk(pclk), .presetn(presetn), .bit_clks(16'd64),
      .nine_bit(nine_bit), .send_req(send_req), .send_sync(send_sync),
      .send_data(send_data), .send_ready(send_ready), .rcv_data(rcv_data),
      .rcv_valid(rcv_valid), .lnk(lnk));
   uab_monitor #(.BITC(64)) i_uab_monitor(.pclk(pclk), .presetn(presetn),
      .dev_txd(lnk.dev_txd), .rem_txd(lnk.rem_txd));
   always #50 pclk = ~pclk;
   task automatic end_sim();
      $display("counts: %0d checks, %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tmo();
      fails++;
      $display("MISMATCH %0t wait timed out", $time);
      end_sim();
   endtask
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) tmo();
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, '0);
   endtask
   task automatic poll(input logic [11:0] a, input int b, input logic v);
      int n;
      n = 0;
      do begin
         rd(a);
         n++;
      end while (rdat[b] !== v && n < 500);
      if (rdat[b] !== v) tmo();
   endtask
   // Blocks until the remote has finished the whole frame
   task automatic send(input logic s, input logic [8:0] d);
      @(posedge pclk);
      send_req <= ~s;
      send_sync <= s;
      send_data <= d;
      @(posedge pclk);
      send_req <= 1'b0;
      send_sync <= 1'b0;
      repeat (2) @(posedge pclk);
      poll_ready();
   endtask
   task automatic poll_ready();
      int n;
      for (n = 0; n < 2000 && send_ready !== 1'b1; n++) @(posedge pclk);
      if (send_ready !== 1'b1) tmo();
   endtask
   task automatic rcv(input logic [8:0] e, input string m);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rcv_valid !== 1'b1 && n < 2000);
      if (rcv_valid !== 1'b1) tmo();
      chk(rcv_data === e, m);
   endtask
   task automatic t_reset();
      chk(lnk.dev_txd === 1'b1, "line idle");
      rd(`UAB_STAT_OFF);
      chk(rdat === (32'h1 << `UAB_S_SHIFTER_EMPTY_BIT), "stat reset");
      rd(12'h020);
      chk(perr === 1'b1, "unmapped");
      apb(1'b1, `UAB_CTRL_OFF, c_ov);
      rd(`UAB_CTRL_OFF);
      chk(rdat === c_ov, "ovf set");
      apb(1'b1, `UAB_CTRL_OFF, `UAB_WORD_RST);
      rd(`UAB_CTRL_OFF);
      chk(rdat === `UAB_WORD_RST, "ovf clear");
      $display("test reset done");
   endtask
   task automatic t_flag();
      apb(1'b1, `UAB_CTRL_OFF, c_sp);
      rd(`UAB_STAT_OFF);
      chk(rdat[`UAB_S_TXBE] === 1'b0, "flag early");
      apb(1'b1, `UAB_CTRL_OFF, c_sp | c_tx);
      apb(1'b1, `UAB_STAT_OFF, `UAB_WORD_RST);
      rd(`UAB_STAT_OFF);
      chk(rdat[`UAB_S_TXBE] === 1'b1 && txe_req === 1'b0, "flag on");
      apb(1'b1, `UAB_CTRL_OFF, c_sp | c_tx | c_ie);
      repeat (2) @(posedge pclk);
      chk(txe_req === 1'b1, "request");
      $display("test flag done");
   endtask
   task automatic t_tx();
      logic [31:0] cf[3] = '{c_hi | c_wi, c_hi, 32'h0};
      logic [7:0] dt[3] = '{8'h96, 8'h3c, 8'he1};
      logic [15:0] dv[3] = '{16'd15, 16'd3, 16'd0};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, `UAB_DIV_OFF, {16'h0, dv[i]});
         apb(1'b1, `UAB_CTRL_OFF, c_sp | c_tx | cf[i]);
         apb(1'b1, `UAB_TXD_OFF, {24'h0, dt[i]});
         rcv({1'b0, dt[i]}, "tx byte");
         poll(`UAB_STAT_OFF, `UAB_S_SHIFTER_EMPTY_BIT, 1'b1);
      end
      nine_bit <= 1'b1;
      apb(1'b1, `UAB_CTRL_OFF, c_sp | c_tx | c_t9 | c_td);
      apb(1'b1, `UAB_TXD_OFF, 32'h0000_0081);
      rcv(9'h181, "ninth bit");
      poll(`UAB_STAT_OFF, `UAB_S_SHIFTER_EMPTY_BIT, 1'b1);
      nine_bit <= 1'b0;
      $display("test tx done");
   endtask
   task automatic t_b2b();
      apb(1'b1, `UAB_CTRL_OFF, c_sp | c_tx);
      apb(1'b1, `UAB_TXD_OFF, 32'h0000_0011);
      // Let the first byte leave the buffer before the second lands
      repeat (4) @(posedge pclk);
      apb(1'b1, `UAB_TXD_OFF, 32'h0000_0022);
      repeat (8) @(posedge pclk);
      rd(`UAB_STAT_OFF);
      chk(rdat[1:0] === 2'b00, "buffer full");
      rcv(9'h011, "first byte");
      repeat (64) @(posedge pclk);
      rd(`UAB_STAT_OFF);
      chk(rdat[1:0] === 2'b01, "reloaded");
      rcv(9'h022, "second byte");
      poll(`UAB_STAT_OFF, `UAB_S_SHIFTER_EMPTY_BIT, 1'b1);
      $display("test b2b done");
   endtask
   task automatic measure(input logic [31:0] cf, input int ex);
      apb(1'b1, `UAB_DIV_OFF, 32'h0000_1234);
      apb(1'b1, `UAB_CTRL_OFF, c_sp | c_ab | cf);
      rd(`UAB_DIV_OFF);
      chk(rdat === `UAB_WORD_RST && rx_hold === 1'b1, "armed");
      if ((cf & c_wu) != 0) begin
         send(1'b0, 9'h000);
         rd(`UAB_CTRL_OFF);
         chk(rdat[`UAB_C_AUTOBAUD_ENABLE] === 1'b1, "break skipped");
      end
      send(1'b1, 9'h000);
      poll(`UAB_CTRL_OFF, `UAB_C_AUTOBAUD_ENABLE, 1'b0);
      rd(`UAB_STAT_OFF);
      chk(rdat[`UAB_S_RCF] === 1'b1 && rx_hold === 1'b0, "done flag");
      rd(`UAB_DIV_OFF);
      chk(rdat >= ex - 1 && rdat <= ex + 1, "count");
      rd(`UAB_RXD_OFF);
      rd(`UAB_STAT_OFF);
      chk(rdat[`UAB_S_RCF] === 1'b0, "flag read clear");
   endtask
   task automatic t_abd();
      apb(1'b1, `UAB_CTRL_OFF, c_sp | c_sy | c_ab);
      rd(`UAB_CTRL_OFF);
      chk(rdat[`UAB_C_AUTOBAUD_ENABLE] === 1'b0, "sync refused");
      measure(c_hi | c_wi, 16);
      measure(c_hi, 4);
      measure(c_wi, 4);
      measure(32'h0, 1);
      measure(c_wu | c_hi | c_wi, 16);
      $display("test abd done");
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, nine_bit, send_req, send_sync} = '0;
      paddr = '0;
      pwdata = '0;
      send_data = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_flag();
      t_tx();
      t_b2b();
      t_abd();
      end_sim();
   end
endmodule
